// file: regctl_consts.svh
// Offsets, field positions, reset values and page codes of the bank
`ifndef REGCTL_CONSTS_SVH
`define REGCTL_CONSTS_SVH

`define REGCTL_AW 8
`define REGCTL_DW 8

`define REGCTL_OFS_AUX 8'h6F
`define REGCTL_OFS_LIN3 8'h70
`define REGCTL_OFS_LIN4 8'h71
`define REGCTL_OFS_STAT 8'h7E
`define REGCTL_OFS_PAGE 8'h7F
`define REGCTL_OFS_EXT_BASE 8'h80

`define REGCTL_BIT_OFF_MODE 7
`define REGCTL_BIT_LOW_PWR 6
`define REGCTL_BIT_STBY_OFF 5
`define REGCTL_BIT_ENABLE 4
`define REGCTL_AUX_VBITS 2
`define REGCTL_LIN_VBITS 4

`define REGCTL_PAGE_FUNC 4'h0
`define REGCTL_PAGE_EXT1 4'h1
`define REGCTL_PAGE_EXT2 4'h2
`define REGCTL_PAGE_RST 4'h0

`define REGCTL_STAT_LOAD_DONE 0
`define REGCTL_STAT_SC_SEEN 1
`define REGCTL_STAT_FUSE_1V5 2

`define REGCTL_MODE_RST 3'h0
`define REGCTL_RD_RESERVED 8'h00
`define REGCTL_EXT_DEPTH 16

`endif

// file: regctl_pkg.sv
// Types shared by the regulator control bank
package regctl_pkg;
    typedef logic [7:0] regctl_byte_t;
    typedef enum logic [2:0] {
        REGCTL_K_NONE = 3'b000,
        REGCTL_K_AUX = 3'b001,
        REGCTL_K_LIN3 = 3'b010,
        REGCTL_K_LIN4 = 3'b011,
        REGCTL_K_STAT = 3'b100,
        REGCTL_K_PAGE = 3'b101,
        REGCTL_K_EXT1 = 3'b110,
        REGCTL_K_EXT2 = 3'b111
    } regctl_kind_e;
endpackage

// file: regctl_ctl_reg.sv
// One regulator control register with fuse-loaded enable and voltage code
`timescale 1ns/1ps
`default_nettype none
`include "regctl_consts.svh"
module regctl_ctl_reg #(
    parameter int VBITS = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic mode_rst,
    input wire logic load_rst,
    input wire logic wr,
    input wire regctl_pkg::regctl_byte_t wdata,
    input wire logic [VBITS:0] load_val,
    output regctl_pkg::regctl_byte_t reg_q
);
    import regctl_pkg::*;

    logic [2:0] mode_q;
    logic [VBITS:0] fuse_q;

    // Mode bits: fixed zero default, power-on/off domain
    always_ff @(posedge clk) begin
        if (!nrst || mode_rst) begin
            mode_q <= `REGCTL_MODE_RST;
        end else if (ce && wr) begin
            mode_q <= wdata[7:5];
        end
    end

    // Fuse image follows its source while held; host writes are dropped until release
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fuse_q <= '0;
        end else if (ce) begin
            if (load_rst) begin
                fuse_q <= load_val;
            end else if (wr) begin
                fuse_q <= {wdata[4], wdata[VBITS-1:0]};
            end
        end
    end

    generate
        if (VBITS < 4) begin : g_gap
            // Bits between the code and the enable are reserved, read zero
            assign reg_q = {mode_q, fuse_q[VBITS],
                            {(4 - VBITS){1'b0}}, fuse_q[VBITS-1:0]};
        end else begin : g_full
            assign reg_q = {mode_q, fuse_q};
        end
    endgenerate
endmodule
`default_nettype wire

// file: regctl_bank.sv
// Paged 8-bit register bank holding the regulator control registers
`timescale 1ns/1ps
`default_nettype none
`include "regctl_consts.svh"
// How it works
// - Aux bit 7 picks full off or sleep on enable-pin turn-off.
// - Aux bit 6 allows low-power operation when set.
// - Aux bit 5 turns the regulator off in standby when set.
// - Aux bit 4 enables the regulator.
// - Aux bits 1:0 carry the two-bit voltage code out.
// - Linear three bits 7..4: off mode, low power, standby off, enable.
// - Linear three bits 3:0 carry its four-bit voltage code.
// - Linear four bits 7..4: off mode, low power, standby off, enable.
// - Linear four bits 3:0 carry its four-bit voltage code.
// - Page code 0 functional, 1 extended one, 2 extended two.
// - Addresses and data are all eight bits wide.
// - Low half decodes functional registers, high half the selected extended page, extended one under code 0.
// - Low half is the same whatever page is selected.
// - Functional registers stay reachable while an extended page is set.
// - Reserved addresses read zero and ignore writes.
// - Write-one-clear bits clear only where a one is written.
// - Read-only bits return their value and ignore writes.
// - Fuse bits load at start-up, or built-in defaults on 1.5 V supply.
// - Fuse bits become host writable only after their reset releases.
// - Each stored bit outside the extended pages belongs to one of several separate reset domains.
// - Control and page registers accept reads at any time; writes are dropped while a reset holds their bits.
module regctl_bank #(
    parameter int EXT_DEPTH = `REGCTL_EXT_DEPTH,
    parameter logic [2:0] AUX_DEF = 3'h0,
    parameter logic [4:0] LIN3_DEF = 5'h00,
    parameter logic [4:0] LIN4_DEF = 5'h00
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`REGCTL_AW-1:0] reg_addr,
    input wire regctl_pkg::regctl_byte_t reg_wdata,
    output regctl_pkg::regctl_byte_t reg_rdata,
    output logic reg_rvalid,
    input wire logic short_circuit_reset,
    input wire logic digital_supply_por_n,
    input wire logic digital_reset_n,
    input wire logic power_on_reset_n,
    input wire logic off_request_n,
    input wire logic fuse_load,
    input wire logic fuse_supply_input,
    input wire logic [2:0] fuse_aux,
    input wire logic [4:0] fuse_lin3,
    input wire logic [4:0] fuse_lin4,
    output logic aux_off_mode_sel,
    output logic aux_low_power_allow,
    output logic aux_standby_off,
    output logic aux_enable,
    output logic [1:0] aux_regulator,
    output logic lin3_off_mode_sel,
    output logic lin3_low_power_allow,
    output logic lin3_standby_off,
    output logic lin3_enable,
    output logic [3:0] linear_regulator_three,
    output logic lin4_off_mode_sel,
    output logic lin4_low_power_allow,
    output logic lin4_standby_off,
    output logic lin4_enable,
    output logic [3:0] linear_regulator_four,
    output logic [3:0] page_sel
);
    import regctl_pkg::*;

    localparam int EAW = $clog2(EXT_DEPTH);

    // Which storage an address reaches under a given page code
    function automatic regctl_kind_e addr_kind(
        input logic [7:0] a,
        input logic [3:0] pg
    );
        regctl_kind_e k;
        k = REGCTL_K_NONE;
        if (!a[7]) begin
            // Page code never consulted here
            case (a)
                `REGCTL_OFS_AUX: k = REGCTL_K_AUX;
                `REGCTL_OFS_LIN3: k = REGCTL_K_LIN3;
                `REGCTL_OFS_LIN4: k = REGCTL_K_LIN4;
                `REGCTL_OFS_STAT: k = REGCTL_K_STAT;
                `REGCTL_OFS_PAGE: k = REGCTL_K_PAGE;
                default: k = REGCTL_K_NONE;
            endcase
        end else if ({1'b0, a[6:0]} < 8'(EXT_DEPTH)) begin
            // Functional code shares the first extended layout
            case (pg)
                `REGCTL_PAGE_FUNC: k = REGCTL_K_EXT1;
                `REGCTL_PAGE_EXT1: k = REGCTL_K_EXT1;
                `REGCTL_PAGE_EXT2: k = REGCTL_K_EXT2;
                default: k = REGCTL_K_NONE;
            endcase
        end
        return k;
    endfunction

    logic [3:0] page_q;
    logic load_done_q;
    logic sc_seen_q;
    logic mode_rst;
    logic load_rst;
    logic load_rst_q;
    logic wr_aux;
    logic wr_lin3;
    logic wr_lin4;
    regctl_kind_e wr_kind;
    regctl_kind_e rd_kind;
    regctl_byte_t aux_q;
    regctl_byte_t lin3_q;
    regctl_byte_t lin4_q;
    regctl_byte_t stat_rd;
    regctl_byte_t ext1_mem [EXT_DEPTH];
    regctl_byte_t ext2_mem [EXT_DEPTH];
    logic [2:0] aux_load;
    logic [4:0] lin3_load;
    logic [4:0] lin4_load;
    logic [EAW-1:0] ext_idx;
    logic wr_page;
    logic wr_stat;
    logic wr_ext1;
    logic wr_ext2;
    regctl_byte_t rd_word;

    // Reset domains; nrst covers all of them
    assign mode_rst = !power_on_reset_n || !off_request_n;
    assign load_rst = fuse_load;

    // 1.5 V on the fuse supply means the fuses are not trusted
    assign aux_load = fuse_supply_input ? AUX_DEF : fuse_aux;
    assign lin3_load = fuse_supply_input ? LIN3_DEF : fuse_lin3;
    assign lin4_load = fuse_supply_input ? LIN4_DEF : fuse_lin4;

    // Decode is combinational so access needs no wait state
    assign wr_kind = addr_kind(reg_addr, page_q);
    assign rd_kind = addr_kind(reg_addr, page_q);
    assign wr_aux = reg_wr && (wr_kind == REGCTL_K_AUX);
    assign wr_lin3 = reg_wr && (wr_kind == REGCTL_K_LIN3);
    assign wr_lin4 = reg_wr && (wr_kind == REGCTL_K_LIN4);
    assign ext_idx = reg_addr[EAW-1:0];

    // One strobe per target keeps each process to a single condition
    assign wr_page = reg_wr && (wr_kind == REGCTL_K_PAGE);
    assign wr_stat = reg_wr && (wr_kind == REGCTL_K_STAT);
    assign wr_ext1 = reg_wr && (wr_kind == REGCTL_K_EXT1);
    assign wr_ext2 = reg_wr && (wr_kind == REGCTL_K_EXT2);

    regctl_ctl_reg #(
        .VBITS(`REGCTL_AUX_VBITS)
    ) u_aux (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .mode_rst(mode_rst),
        .load_rst(load_rst),
        .wr(wr_aux),
        .wdata(reg_wdata),
        .load_val(aux_load),
        .reg_q(aux_q)
    );

    regctl_ctl_reg #(
        .VBITS(`REGCTL_LIN_VBITS)
    ) u_lin3 (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .mode_rst(mode_rst),
        .load_rst(load_rst),
        .wr(wr_lin3),
        .wdata(reg_wdata),
        .load_val(lin3_load),
        .reg_q(lin3_q)
    );

    regctl_ctl_reg #(
        .VBITS(`REGCTL_LIN_VBITS)
    ) u_lin4 (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .mode_rst(mode_rst),
        .load_rst(load_rst),
        .wr(wr_lin4),
        .wdata(reg_wdata),
        .load_val(lin4_load),
        .reg_q(lin4_q)
    );

    // Controls straight from the register flops
    assign aux_off_mode_sel = aux_q[`REGCTL_BIT_OFF_MODE];
    assign aux_low_power_allow = aux_q[`REGCTL_BIT_LOW_PWR];
    assign aux_standby_off = aux_q[`REGCTL_BIT_STBY_OFF];
    assign aux_enable = aux_q[`REGCTL_BIT_ENABLE];
    assign aux_regulator = aux_q[`REGCTL_AUX_VBITS-1:0];
    assign lin3_off_mode_sel = lin3_q[`REGCTL_BIT_OFF_MODE];
    assign lin3_low_power_allow = lin3_q[`REGCTL_BIT_LOW_PWR];
    assign lin3_standby_off = lin3_q[`REGCTL_BIT_STBY_OFF];
    assign lin3_enable = lin3_q[`REGCTL_BIT_ENABLE];
    assign linear_regulator_three = lin3_q[3:0];
    assign lin4_off_mode_sel = lin4_q[`REGCTL_BIT_OFF_MODE];
    assign lin4_low_power_allow = lin4_q[`REGCTL_BIT_LOW_PWR];
    assign lin4_standby_off = lin4_q[`REGCTL_BIT_STBY_OFF];
    assign lin4_enable = lin4_q[`REGCTL_BIT_ENABLE];
    assign linear_regulator_four = lin4_q[3:0];
    assign page_sel = page_q;

    // Page register, digital reset domain; upper nibble reserved
    always_ff @(posedge clk) begin
        if (!nrst || !digital_reset_n) begin
            page_q <= `REGCTL_PAGE_RST;
        end else if (ce && wr_page) begin
            page_q <= reg_wdata[3:0];
        end
    end

    // Delayed load flag marks the end of a fuse load
    always_ff @(posedge clk) begin
        if (!nrst) begin
            load_rst_q <= 1'b0;
        end else if (ce) begin
            load_rst_q <= load_rst;
        end
    end

    // Load-done sticky: short-circuit plus digital supply domain
    always_ff @(posedge clk) begin
        if (!nrst || short_circuit_reset || !digital_supply_por_n) begin
            load_done_q <= 1'b0;
        end else if (ce) begin
            // Set beats a clear in the same cycle
            if (load_rst_q && !load_rst) begin
                load_done_q <= 1'b1;
            end else if (wr_stat &&
                         reg_wdata[`REGCTL_STAT_LOAD_DONE]) begin
                load_done_q <= 1'b0;
            end
        end
    end

    // Short-circuit sticky: digital supply domain alone
    always_ff @(posedge clk) begin
        if (!nrst || !digital_supply_por_n) begin
            sc_seen_q <= 1'b0;
        end else if (ce) begin
            if (short_circuit_reset) begin
                sc_seen_q <= 1'b1;
            end else if (wr_stat &&
                         reg_wdata[`REGCTL_STAT_SC_SEEN]) begin
                sc_seen_q <= 1'b0;
            end
        end
    end

    // Fuse supply level is read-only, writes have no path to it
    assign stat_rd = {5'h00, fuse_supply_input, sc_seen_q,
                      load_done_q};

    // Extended page storage; contents survive page switches
    always_ff @(posedge clk) begin
        if (ce && wr_ext1) begin
            ext1_mem[ext_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && wr_ext2) begin
            ext2_mem[ext_idx] <= reg_wdata;
        end
    end

    // Read mux; unmapped kinds fall through to the reserved value
    always_comb begin
        case (rd_kind)
            REGCTL_K_AUX: rd_word = aux_q;
            REGCTL_K_LIN3: rd_word = lin3_q;
            REGCTL_K_LIN4: rd_word = lin4_q;
            REGCTL_K_STAT: rd_word = stat_rd;
            REGCTL_K_PAGE: rd_word = {4'h0, page_q};
            REGCTL_K_EXT1: rd_word = ext1_mem[ext_idx];
            REGCTL_K_EXT2: rd_word = ext2_mem[ext_idx];
            default: rd_word = `REGCTL_RD_RESERVED;
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= `REGCTL_RD_RESERVED;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_word;
            end
        end
    end
endmodule
`default_nettype wire

// file: regctl_bank_props.sv
// Port checks for the regulator control bank
`timescale 1ns/1ps
`default_nettype none
`include "regctl_consts.svh"
module regctl_bank_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`REGCTL_AW-1:0] reg_addr,
    input wire regctl_pkg::regctl_byte_t reg_wdata,
    input wire regctl_pkg::regctl_byte_t reg_rdata,
    input wire logic reg_rvalid,
    input wire logic power_on_reset_n,
    input wire logic off_request_n,
    input wire logic digital_reset_n,
    input wire logic fuse_load,
    input wire logic fuse_supply_input,
    input wire logic [2:0] fuse_aux,
    input wire logic aux_off_mode_sel,
    input wire logic aux_low_power_allow,
    input wire logic aux_standby_off,
    input wire logic aux_enable,
    input wire logic [1:0] aux_regulator,
    input wire logic lin3_off_mode_sel,
    input wire logic lin3_low_power_allow,
    input wire logic lin3_standby_off,
    input wire logic lin3_enable,
    input wire logic [3:0] linear_regulator_three,
    input wire logic lin4_off_mode_sel,
    input wire logic lin4_low_power_allow,
    input wire logic lin4_standby_off,
    input wire logic lin4_enable,
    input wire logic [3:0] linear_regulator_four,
    input wire logic [3:0] page_sel
);
    import regctl_pkg::*;
    logic [7:0] aux_v, lin3_v, lin4_v;
    logic wr_ok;
    // Fuse load and both reset inputs would override a plain write
    assign wr_ok = ce && reg_wr && !fuse_load && power_on_reset_n
        && off_request_n;
    assign aux_v = {aux_off_mode_sel, aux_low_power_allow, aux_standby_off,
        aux_enable, 2'b00, aux_regulator};
    assign lin3_v = {lin3_off_mode_sel, lin3_low_power_allow,
        lin3_standby_off, lin3_enable, linear_regulator_three};
    assign lin4_v = {lin4_off_mode_sel, lin4_low_power_allow,
        lin4_standby_off, lin4_enable, linear_regulator_four};
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    aux_write_a: assert property (
        wr_ok && reg_addr == `REGCTL_OFS_AUX |=> aux_v ==
        {$past(reg_wdata[7:4]), 2'b00, $past(reg_wdata[1:0])})
        else $error("aux outputs differ from written byte");
    lin3_write_a: assert property (
        wr_ok && reg_addr == `REGCTL_OFS_LIN3 |=> lin3_v == $past(reg_wdata))
        else $error("linear three outputs differ from written byte");
    lin4_write_a: assert property (
        wr_ok && reg_addr == `REGCTL_OFS_LIN4 |=> lin4_v == $past(reg_wdata))
        else $error("linear four outputs differ from written byte");
    page_write_a: assert property (
        ce && reg_wr && reg_addr == `REGCTL_OFS_PAGE && digital_reset_n
        |=> page_sel == $past(reg_wdata[3:0]))
        else $error("page select differs from written code");
    read_valid_a: assert property (ce && reg_rd |=> reg_rvalid)
        else $error("read answer missing one cycle later");
    valid_pulse_a: assert property (ce && !reg_rd |=> !reg_rvalid)
        else $error("read valid without a taken read");
    reserved_zero_a: assert property (
        ce && reg_rd && reg_addr >= `REGCTL_OFS_EXT_BASE + `REGCTL_EXT_DEPTH
        |=> reg_rdata == 8'h00)
        else $error("reserved read not zero");
    lin3_read_a: assert property (
        ce && reg_rd && reg_addr == `REGCTL_OFS_LIN3
        |=> reg_rdata == $past(lin3_v))
        else $error("linear three read differs from register");
    fuse_follow_a: assert property (
        ce && fuse_load && !fuse_supply_input
        |=> {aux_enable, aux_regulator} == $past(fuse_aux))
        else $error("aux enable and code do not follow fuses");
    por_mode_a: assert property (
        ce && !power_on_reset_n
        |=> {aux_v[7:5], lin3_v[7:5], lin4_v[7:5]} == 9'h000)
        else $error("mode bits survive power-on reset");
    reset_page_a: assert property (
        $rose(nrst) |-> page_sel == 4'h0 && !reg_rvalid)
        else $error("page or valid not cleared by reset");
endmodule
`default_nettype wire

// file: regctl_host.sv
// Host model issuing single-byte register requests
`timescale 1ns/1ps
`default_nettype none
module regctl_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output regctl_pkg::regctl_byte_t reg_wdata
);
    import regctl_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One request per edge, any address, any time
    task automatic op(input logic w, input logic r, input logic [7:0] a,
            input regctl_byte_t d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    // Released lines flip so a stale value is never read as live
    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: regctl_bank_tb.sv
// Self-checking bench for the regulator control bank
`timescale 1ns/1ps
`default_nettype none
`include "regctl_consts.svh"
module regctl_bank_tb;
    import regctl_pkg::*;
    logic clk, nrst, ce, reg_wr, reg_rd, reg_rvalid, fl, fsi, sc, dsp_n;
    logic por_n, off_n, dig_n, ce_q;
    logic [7:0] reg_addr;
    regctl_byte_t reg_wdata, reg_rdata, d;
    logic [2:0] f_aux;
    logic [4:0] f_l3, f_l4;
    logic [31:0] seed = 32'h2FD9D4D3;
    regctl_byte_t exp_q[$];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    regctl_bank #(.AUX_DEF(3'h5), .LIN3_DEF(5'h1A), .LIN4_DEF(5'h07))
        regctl_bank_inst (.clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .short_circuit_reset(sc), .digital_supply_por_n(dsp_n),
        .digital_reset_n(dig_n), .power_on_reset_n(por_n),
        .off_request_n(off_n), .fuse_load(fl), .fuse_supply_input(fsi),
        .fuse_aux(f_aux), .fuse_lin3(f_l3), .fuse_lin4(f_l4),
        .aux_off_mode_sel(), .aux_low_power_allow(), .aux_standby_off(),
        .aux_enable(), .aux_regulator(), .lin3_off_mode_sel(),
        .lin3_low_power_allow(), .lin3_standby_off(), .lin3_enable(),
        .linear_regulator_three(), .lin4_off_mode_sel(),
        .lin4_low_power_allow(), .lin4_standby_off(), .lin4_enable(),
        .linear_regulator_four(), .page_sel());
    regctl_host regctl_host_inst (.clk(clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input regctl_byte_t seen,
            input regctl_byte_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input regctl_byte_t v);
        regctl_host_inst.op(1'b1, 1'b0, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input regctl_byte_t e);
        exp_q.push_back(e);
        regctl_host_inst.op(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ce_q <= ce;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end else if (reg_rvalid === 1'b1 && ce_q === 1'b1) begin
            // A valid held by a low enable is not a new answer
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("unexpected read: expected none, seen %h", reg_rdata);
            end else
                check("read data", reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        {nrst, fl, fsi, sc} = 4'h0;
        {ce, dsp_n, dig_n, por_n, off_n} = 5'h1F;
        {f_aux, f_l3, f_l4} = 13'h0000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(`REGCTL_OFS_PAGE, 8'h00);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            {f_aux, f_l3, f_l4} <= seed[12:0];
            fsi <= i[0];
            fl <= 1'b1;
            regctl_host_inst.idle();
            fl <= 1'b0;
            repeat (2) regctl_host_inst.idle();
            d = i ? 8'h11 : {3'b000, seed[12], 2'b00, seed[11:10]};
            rd(`REGCTL_OFS_AUX, d);
            rd(`REGCTL_OFS_LIN3, i ? 8'h1A : {3'b000, seed[9:5]});
            rd(`REGCTL_OFS_LIN4, i ? 8'h07 : {3'b000, seed[4:0]});
            wr(`REGCTL_OFS_STAT, 8'h00);
            rd(`REGCTL_OFS_STAT, {5'h00, i[0], 2'b01});
            wr(`REGCTL_OFS_STAT, 8'hFF);
            rd(`REGCTL_OFS_STAT, {5'h00, i[0], 2'b00});
        end
        fsi <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr(`REGCTL_OFS_PAGE, {seed[31:28], 4'(i % 3)});
            wr(`REGCTL_OFS_AUX, seed[7:0]);
            wr(`REGCTL_OFS_LIN3, seed[15:8]);
            wr(`REGCTL_OFS_LIN4, seed[23:16]);
            rd(`REGCTL_OFS_AUX, {seed[7:4], 2'b00, seed[1:0]});
            rd(`REGCTL_OFS_LIN3, seed[15:8]);
            rd(`REGCTL_OFS_LIN4, seed[23:16]);
            rd(`REGCTL_OFS_PAGE, {4'h0, 4'(i % 3)});
        end
        // Read and write together: the read returns the old byte
        exp_q.push_back({seed[7:4], 2'b00, seed[1:0]});
        regctl_host_inst.op(1'b1, 1'b1, `REGCTL_OFS_AUX, 8'h00);
        rd(`REGCTL_OFS_AUX, 8'h00);
        f_aux <= 3'h2;
        fl <= 1'b1;
        regctl_host_inst.idle();
        wr(`REGCTL_OFS_AUX, 8'hFF);
        fl <= 1'b0;
        rd(`REGCTL_OFS_AUX, 8'hE2);
        ce <= 1'b0;
        wr(`REGCTL_OFS_AUX, 8'h00);
        ce <= 1'b1;
        rd(`REGCTL_OFS_AUX, 8'hE2);
        por_n <= 1'b0;
        regctl_host_inst.idle();
        por_n <= 1'b1;
        rd(`REGCTL_OFS_AUX, 8'h02);
        rd(`REGCTL_OFS_LIN3, {3'b000, f_l3});
        wr(`REGCTL_OFS_AUX, 8'hFF);
        off_n <= 1'b0;
        regctl_host_inst.idle();
        off_n <= 1'b1;
        rd(`REGCTL_OFS_AUX, 8'h13);
        wr(`REGCTL_OFS_PAGE, 8'h01);
        wr(8'h85, 8'h3C);
        wr(`REGCTL_OFS_PAGE, 8'h02);
        wr(8'h85, 8'hA5);
        rd(8'h85, 8'hA5);
        wr(`REGCTL_OFS_PAGE, 8'h00);
        rd(8'h85, 8'h3C);
        wr(`REGCTL_OFS_PAGE, 8'h03);
        rd(8'h85, 8'h00);
        wr(8'h95, 8'h77);
        rd(8'h95, 8'h00);
        wr(8'h40, 8'h77);
        rd(8'h40, 8'h00);
        dig_n <= 1'b0;
        regctl_host_inst.idle();
        dig_n <= 1'b1;
        rd(`REGCTL_OFS_PAGE, 8'h00);
        sc <= 1'b1;
        regctl_host_inst.idle();
        sc <= 1'b0;
        rd(`REGCTL_OFS_STAT, 8'h02);
        dsp_n <= 1'b0;
        regctl_host_inst.idle();
        dsp_n <= 1'b1;
        rd(`REGCTL_OFS_STAT, 8'h00);
        wr(`REGCTL_OFS_PAGE, 8'h02);
        nrst <= 1'b0;
        regctl_host_inst.idle();
        nrst <= 1'b1;
        rd(`REGCTL_OFS_PAGE, 8'h00);
        repeat (3) regctl_host_inst.idle();
        if (exp_q.size() != 0)
            n_fail++;
        finish_test();
    end
endmodule
bind regctl_bank regctl_bank_props regctl_bank_props_inst (.clk(clk),
    .nrst(nrst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_on_reset_n(power_on_reset_n),
    .off_request_n(off_request_n), .digital_reset_n(digital_reset_n),
    .fuse_load(fuse_load), .fuse_supply_input(fuse_supply_input),
    .fuse_aux(fuse_aux), .aux_off_mode_sel(aux_off_mode_sel),
    .aux_low_power_allow(aux_low_power_allow),
    .aux_standby_off(aux_standby_off), .aux_enable(aux_enable),
    .aux_regulator(aux_regulator), .lin3_off_mode_sel(lin3_off_mode_sel),
    .lin3_low_power_allow(lin3_low_power_allow),
    .lin3_standby_off(lin3_standby_off), .lin3_enable(lin3_enable),
    .linear_regulator_three(linear_regulator_three),
    .lin4_off_mode_sel(lin4_off_mode_sel),
    .lin4_low_power_allow(lin4_low_power_allow),
    .lin4_standby_off(lin4_standby_off), .lin4_enable(lin4_enable),
    .linear_regulator_four(linear_regulator_four), .page_sel(page_sel));
`default_nettype wire
